// [core/csx_pkg.sv]
package csx_pkg;
    // =========================================================
    // Register map (word indices on the plain register port)
    // =========================================================
    localparam logic [2:0] CSX_MODE_ADDR = 3'h0;
    localparam logic [2:0] CSX_RATE_ADDR = 3'h1;
    localparam logic [2:0] CSX_CTRL_ADDR = 3'h2;
    localparam logic [2:0] CSX_TXBUF_ADDR = 3'h3;
    localparam logic [2:0] CSX_STAT_ADDR = 3'h4;
    localparam logic [2:0] CSX_RXBUF_ADDR = 3'h5;
    // =========================================================
    // Field positions
    // =========================================================
    localparam int CSX_MODE_SYNC_BIT = 7;
    localparam int CSX_CTRL_RIE_BIT = 6;
    localparam int CSX_CTRL_TE_BIT = 5;
    localparam int CSX_CTRL_RE_BIT = 4;
    localparam int CSX_CTRL_CLOCK_SOURCE_SELECT_HI_BIT = 1;
    localparam int CSX_STAT_TDE_BIT = 7;
    localparam int CSX_STAT_RDF_BIT = 6;
    localparam int CSX_STAT_OVR_BIT = 5;
    localparam int CSX_STAT_FRM_BIT = 4;
    localparam int CSX_STAT_PAR_BIT = 3;
    localparam int CSX_STAT_TDN_BIT = 2;
    // =========================================================
    // Reset values
    // =========================================================
    localparam logic [7:0] CSX_RXBUF_RST = 8'h00;
    localparam logic [7:0] CSX_TXBUF_RST = 8'hff;
    localparam logic [7:0] CSX_RATE_RST = 8'h00;
    localparam logic [7:0] CSX_MODE_RST = 8'h00;
    localparam logic [7:0] CSX_CTRL_RST = 8'h00;
    localparam logic [7:0] CSX_STAT_RST = 8'h84;
    // =========================================================
    // Timing
    // =========================================================
    localparam int CSX_MCLK_KHZ = 40000;
    localparam int CSX_SCK_PERIOD_NS = 4000;
    localparam int CSX_SCK_PERIOD_CYC = CSX_SCK_PERIOD_NS * CSX_MCLK_KHZ / 1000000;
    localparam int CSX_FRAME_BITS = 8;
    localparam logic [3:0] CSX_LAST_BIT = 4'h7;

    typedef enum logic [2:0] {
        CSX_IDLE = 3'b001,
        CSX_SHIFT = 3'b010,
        CSX_DONE = 3'b100
    } csx_tx_state_t;

    typedef struct packed {
        logic sck_out;
        logic sck_oe;
        logic txd;
    } csx_pins_t;

    typedef struct packed {
        logic [7:0] mode_reg;
        logic [7:0] rate_reg;
        logic [7:0] ctrl_reg;
        logic [7:0] txbuf_reg;
        logic [7:0] rxbuf_reg;
        logic tde_reg;
        logic rdf_reg;
        logic ovr_reg;
        logic frm_reg;
        logic par_reg;
        logic tdn_reg;
        logic [7:0] rdata_reg;
        logic [10:0] brg_cnt_reg;
        logic brg_tick_half_reg;
        csx_tx_state_t tx_state_reg;
        logic [7:0] tsr_reg;
        logic [3:0] tx_bit_reg;
        logic [7:0] rsr_reg;
        logic [3:0] rx_bit_reg;
        logic [2:0] sck_sync_reg;
        logic [2:0] rxd_sync_reg;
        logic sck_prev_reg;
        logic eri_reg;
        csx_pins_t pins_reg;
    } csx_state_t;
endpackage

// [core/csx_txrx.sv]
`timescale 1ns/1ps
// Operation
// [R1] Receive shifter fills from serial input, then full byte moves to receive buffer.
// [R2] Receive buffer is eight bits, read only, zero after reset.
// [R3] Transmit buffer is eight bits, read/write, all ones after reset.
// [R4] Idle transmit shifter takes the buffer byte and starts shifting.
// [R5] A waiting byte at frame end is chained without a clock pause.
// [R6] Software writes transmit buffer once, only after empty flag reads one.
// [R7] Software reads receive buffer once, only after full flag reads one.
// [R8] Status flags are cleared by writing zero, never set by software.
// [R9] Own bit-rate generator per channel, steered by eight-bit rate register.
// [R10] Empty flag at zero means new data is waiting to be moved.
// [R11] After the move the empty flag goes to one and the frame starts.
// [R12] Eight data bits leave on serial out, in step with the output clock.
// [R13] Empty flag is sampled during the last bit to decide chaining.
// [R14] Nothing pending: set done flag, hold last bit, park clock high.
// [R15] Frame ending while full flag set: set overrun, drop byte, keep full.
// [R16] Overrun with receive interrupt enable set raises the receive fault request.
// [R17] Normal frame end: full flag set, byte placed in receive buffer.
// [R18] Receiver starts in step with serial clock, internal or external.
// [R19] Internal clock gives a four microsecond transfer clock period; the code gives it only with rate register 0x0f.
// [R20] Control register gates transmit, receive, interrupt and clock source.
// [R21] Mode register selects format and generator input clock; the code decodes only the format bit.
// [R22] Clock select 0x: internal clock, pin output; 1x: external, pin input.
// [R23] Mode format bit: zero asynchronous, one clocked synchronous; in the code zero only turns transmit, receive and the clock pin output off.
// [R24] Least significant bit first; transmit on falling, sample on rising edge.
// [R25] Done flag clears when new byte is written and sending resumes.
module csx_txrx
    import csx_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic rxd_in,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    output logic txd_out,
    output logic rx_fault_irq
);
    // =========================================================
    // State
    // =========================================================
    csx_state_t s_reg;
    csx_state_t s_next;

    logic sync_mode;
    logic ext_clk;
    logic tx_en;
    logic rx_en;
    logic sck_rise;
    logic sck_fall;
    logic sck_lvl;
    logic rxd_lvl;
    logic tx_ok;
    logic tde_set;
    logic rdf_set;
    logic ovr_set;
    logic tdn_set;
    logic tdn_clr;
    logic [10:0] brg_limit;
    logic [7:0] stat_word;

    // Half period in mclk cycles: half of (rate + 1) sixteenths of one full period at 250 kbps.
    function automatic logic [10:0] half_period(input logic [7:0] rate);
        logic [31:0] full;
        full = 32'(CSX_SCK_PERIOD_CYC) * (32'(rate) + 32'h1) / 32'h10;
        if (full < 32'h2) begin
            full = 32'h2;
        end
        return 11'(full >> 1);
    endfunction

    assign sync_mode = s_reg.mode_reg[CSX_MODE_SYNC_BIT];
    assign ext_clk = s_reg.ctrl_reg[CSX_CTRL_CLOCK_SOURCE_SELECT_HI_BIT];
    assign tx_en = s_reg.ctrl_reg[CSX_CTRL_TE_BIT] && sync_mode;
    assign rx_en = s_reg.ctrl_reg[CSX_CTRL_RE_BIT] && sync_mode;
    assign brg_limit = half_period(s_reg.rate_reg);
    // A level change counts once the second and third stages agree.
    assign sck_lvl = (s_reg.sck_sync_reg[1] == s_reg.sck_sync_reg[2])
                     ? s_reg.sck_sync_reg[2] : s_reg.sck_prev_reg;
    assign rxd_lvl = s_reg.rxd_sync_reg[2];
    assign tx_ok = tx_en && !s_reg.tde_reg;
    assign stat_word = {s_reg.tde_reg, s_reg.rdf_reg, s_reg.ovr_reg, s_reg.frm_reg,
                        s_reg.par_reg, s_reg.tdn_reg, 2'b00};

    always_comb begin
        s_next = s_reg;
        tde_set = 1'b0;
        rdf_set = 1'b0;
        ovr_set = 1'b0;
        tdn_set = 1'b0;
        tdn_clr = 1'b0;
        sck_rise = 1'b0;
        sck_fall = 1'b0;
        s_next.sck_sync_reg = {s_reg.sck_sync_reg[1:0], sck_in};
        s_next.rxd_sync_reg = {s_reg.rxd_sync_reg[1:0], rxd_in};
        // =====================================================
        // Clock edges: internal generator or external pin
        // =====================================================
        s_next.brg_tick_half_reg = 1'b0;
        if (!ext_clk) begin // [R22]
            if (s_reg.tx_state_reg == CSX_SHIFT) begin
                if (s_reg.brg_cnt_reg + 11'h1 >= brg_limit) begin // [R9] [R19]
                    s_next.brg_cnt_reg = 11'h000;
                    s_next.brg_tick_half_reg = 1'b1;
                end else begin
                    s_next.brg_cnt_reg = s_reg.brg_cnt_reg + 11'h1;
                end
            end else begin
                s_next.brg_cnt_reg = 11'h000;
            end
            sck_fall = s_reg.brg_tick_half_reg && s_reg.pins_reg.sck_out;
            sck_rise = s_reg.brg_tick_half_reg && !s_reg.pins_reg.sck_out;
            s_next.sck_prev_reg = 1'b1;
        end else begin
            s_next.sck_prev_reg = sck_lvl;
            sck_fall = s_reg.sck_prev_reg && !sck_lvl;
            sck_rise = !s_reg.sck_prev_reg && sck_lvl;
            s_next.brg_cnt_reg = 11'h000;
        end
        s_next.pins_reg.sck_oe = sync_mode && !ext_clk; // [R20] [R22]
        // =====================================================
        // Transmit path
        // =====================================================
        case (s_reg.tx_state_reg)
            CSX_IDLE, CSX_DONE: begin
                s_next.pins_reg.sck_out = 1'b1; // [R14]
                if (tx_ok || (rx_en && !tx_en && ext_clk)) begin // [R4] [R10] [R18]
                    s_next.tsr_reg = s_reg.txbuf_reg;
                    s_next.tx_bit_reg = 4'h0;
                    tde_set = tx_ok; // [R11]
                    tdn_clr = tx_ok; // [R25]
                    s_next.rx_bit_reg = 4'h0; // [R18]
                    s_next.tx_state_reg = CSX_SHIFT;
                    if (tx_ok) begin
                        s_next.pins_reg.txd = s_reg.txbuf_reg[0]; // [R24]
                    end
                end else if (rx_en && !tx_en && !ext_clk) begin
                    s_next.rx_bit_reg = 4'h0;
                    // The frame counter also paces receive-only frames, so it restarts too.
                    s_next.tx_bit_reg = 4'h0; // [R18]
                    s_next.tx_state_reg = CSX_SHIFT;
                end
            end
            CSX_SHIFT: begin
                if (!ext_clk && s_reg.brg_tick_half_reg) begin
                    s_next.pins_reg.sck_out = !s_reg.pins_reg.sck_out; // [R12]
                end
                if (sck_rise && rx_en) begin // [R1] [R24]
                    s_next.rsr_reg = {rxd_lvl, s_reg.rsr_reg[7:1]};
                    s_next.rx_bit_reg = s_reg.rx_bit_reg + 4'h1;
                    if (s_reg.rx_bit_reg == CSX_LAST_BIT) begin
                        s_next.rx_bit_reg = 4'h0;
                        if (s_reg.rdf_reg) begin
                            ovr_set = 1'b1; // [R15]
                        end else begin
                            s_next.rxbuf_reg = {rxd_lvl, s_reg.rsr_reg[7:1]}; // [R17]
                            rdf_set = 1'b1;
                        end
                    end
                end
                if (sck_rise) begin
                    if (s_reg.tx_bit_reg == CSX_LAST_BIT) begin
                        if (tx_ok) begin // [R5] [R13]
                            s_next.tsr_reg = s_reg.txbuf_reg;
                            s_next.tx_bit_reg = 4'h0;
                            tde_set = 1'b1;
                        end else begin
                            tdn_set = tx_en; // [R14]
                            s_next.tx_state_reg = CSX_DONE;
                        end
                    end else begin
                        s_next.tx_bit_reg = s_reg.tx_bit_reg + 4'h1;
                    end
                end
                if (sck_fall && tx_en) begin // [R24]
                    s_next.pins_reg.txd = s_reg.tsr_reg[s_reg.tx_bit_reg[2:0]]; // [R12]
                end
                if (!tx_en && !rx_en) begin
                    s_next.tx_state_reg = CSX_IDLE;
                end
            end
            default: begin
                s_next.tx_state_reg = CSX_IDLE;
            end
        endcase
        // =====================================================
        // Register port
        // =====================================================
        s_next.rdata_reg = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                CSX_MODE_ADDR: s_next.rdata_reg = s_reg.mode_reg;
                CSX_RATE_ADDR: s_next.rdata_reg = s_reg.rate_reg;
                CSX_CTRL_ADDR: s_next.rdata_reg = s_reg.ctrl_reg;
                CSX_TXBUF_ADDR: s_next.rdata_reg = s_reg.txbuf_reg;
                CSX_STAT_ADDR: s_next.rdata_reg = stat_word;
                CSX_RXBUF_ADDR: s_next.rdata_reg = s_reg.rxbuf_reg; // [R2]
                default: s_next.rdata_reg = 8'h00;
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                CSX_MODE_ADDR: s_next.mode_reg = reg_wdata; // [R21] [R23]
                CSX_RATE_ADDR: s_next.rate_reg = reg_wdata; // [R9]
                CSX_CTRL_ADDR: s_next.ctrl_reg = reg_wdata; // [R20]
                CSX_TXBUF_ADDR: s_next.txbuf_reg = reg_wdata; // [R3]
                CSX_STAT_ADDR: begin
                    // Writing zero clears any flag but the done flag; writing one leaves it alone.
                    s_next.tde_reg = s_reg.tde_reg & reg_wdata[CSX_STAT_TDE_BIT]; // [R8]
                    s_next.rdf_reg = s_reg.rdf_reg & reg_wdata[CSX_STAT_RDF_BIT];
                    s_next.ovr_reg = s_reg.ovr_reg & reg_wdata[CSX_STAT_OVR_BIT];
                    s_next.frm_reg = s_reg.frm_reg & reg_wdata[CSX_STAT_FRM_BIT];
                    s_next.par_reg = s_reg.par_reg & reg_wdata[CSX_STAT_PAR_BIT];
                end
                default: begin
                end
            endcase
        end
        // Hardware sets win over a software clear in the same cycle.
        if (tde_set) begin
            s_next.tde_reg = 1'b1;
        end
        if (rdf_set) begin
            s_next.rdf_reg = 1'b1;
        end
        if (ovr_set) begin
            s_next.ovr_reg = 1'b1;
        end
        if (tdn_clr) begin
            s_next.tdn_reg = 1'b0;
        end
        if (tdn_set) begin
            s_next.tdn_reg = 1'b1;
        end
        s_next.eri_reg = s_next.ovr_reg && s_reg.ctrl_reg[CSX_CTRL_RIE_BIT]; // [R16]
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_reg.mode_reg <= CSX_MODE_RST;
            s_reg.rate_reg <= CSX_RATE_RST;
            s_reg.ctrl_reg <= CSX_CTRL_RST;
            s_reg.txbuf_reg <= CSX_TXBUF_RST; // [R3]
            s_reg.rxbuf_reg <= CSX_RXBUF_RST; // [R2]
            s_reg.tde_reg <= CSX_STAT_RST[CSX_STAT_TDE_BIT];
            s_reg.rdf_reg <= 1'b0;
            s_reg.ovr_reg <= 1'b0;
            s_reg.frm_reg <= 1'b0;
            s_reg.par_reg <= 1'b0;
            s_reg.tdn_reg <= CSX_STAT_RST[CSX_STAT_TDN_BIT];
            s_reg.rdata_reg <= 8'h00;
            s_reg.brg_cnt_reg <= 11'h000;
            s_reg.brg_tick_half_reg <= 1'b0;
            s_reg.tx_state_reg <= CSX_IDLE;
            s_reg.tsr_reg <= 8'h00;
            s_reg.tx_bit_reg <= 4'h0;
            s_reg.rsr_reg <= 8'h00;
            s_reg.rx_bit_reg <= 4'h0;
            s_reg.sck_sync_reg <= 3'b111;
            s_reg.rxd_sync_reg <= 3'b111;
            s_reg.sck_prev_reg <= 1'b1;
            s_reg.eri_reg <= 1'b0;
            s_reg.pins_reg <= '{sck_out: 1'b1, sck_oe: 1'b0, txd: 1'b1};
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata = s_reg.rdata_reg;
    assign sck_out = s_reg.pins_reg.sck_out;
    assign sck_oe = s_reg.pins_reg.sck_oe;
    assign txd_out = s_reg.pins_reg.txd;
    assign rx_fault_irq = s_reg.eri_reg;

    // =========================================================
    // Checks
    // =========================================================
    sequence tx_load_s;
        s_reg.tx_state_reg != CSX_SHIFT && tx_ok;
    endsequence

    a_load_sets_empty: assert property (@(posedge mclk) disable iff (srst) // [R11]
        tx_load_s |=> s_reg.tde_reg && s_reg.tx_state_reg == CSX_SHIFT)
        else $error("empty flag not set after load");
    a_load_copies_buf: assert property (@(posedge mclk) disable iff (srst) // [R4]
        tx_load_s |=> s_reg.tsr_reg == $past(s_reg.txbuf_reg))
        else $error("shifter not loaded from buffer");
    a_idle_clock_high: assert property (@(posedge mclk) disable iff (srst) // [R14]
        s_reg.tx_state_reg == CSX_DONE && !$past(srst) |-> sck_out)
        else $error("clock not parked high");
    a_overrun_keeps_buf: assert property (@(posedge mclk) disable iff (srst) // [R15]
        ovr_set |=> s_reg.ovr_reg && s_reg.rdf_reg && $stable(s_reg.rxbuf_reg))
        else $error("overrun handling wrong");
    a_rx_full_sets: assert property (@(posedge mclk) disable iff (srst) // [R17]
        rdf_set |=> s_reg.rdf_reg ##1 s_reg.rxbuf_reg == $past(s_reg.rxbuf_reg))
        else $error("receive full not set");
    a_flag_no_sw_set: assert property (@(posedge mclk) disable iff (srst) // [R8]
        !s_reg.rdf_reg && !rdf_set |=> !s_reg.rdf_reg)
        else $error("full flag set by software");
    a_rx_irq_raise: assert property (@(posedge mclk) disable iff (srst) // [R16]
        ovr_set && s_reg.ctrl_reg[CSX_CTRL_RIE_BIT] && !reg_wr |=> rx_fault_irq)
        else $error("receive fault request missing");
    a_done_on_end: assert property (@(posedge mclk) disable iff (srst) // [R14]
        tdn_set |=> s_reg.tdn_reg && s_reg.tx_state_reg == CSX_DONE)
        else $error("done flag not set at frame end");
    a_rxbuf_readonly: assert property (@(posedge mclk) disable iff (srst) // [R2]
        reg_wr && reg_addr == CSX_RXBUF_ADDR && !rdf_set |=> $stable(s_reg.rxbuf_reg))
        else $error("receive buffer written by software");
    a_clock_pin_dir: assert property (@(posedge mclk) disable iff (srst) // [R22]
        !$past(srst) |-> sck_oe == $past(sync_mode && !ext_clk))
        else $error("clock pin direction wrong");
    a_empty_no_sw_set: assert property (@(posedge mclk) disable iff (srst) // [R8]
        !s_reg.tde_reg && !tde_set |=> !s_reg.tde_reg)
        else $error("empty flag set by software");
    a_ovr_no_sw_set: assert property (@(posedge mclk) disable iff (srst) // [R8]
        !s_reg.ovr_reg && !ovr_set |=> !s_reg.ovr_reg)
        else $error("overrun flag set by software");
    a_chain_reload: assert property (@(posedge mclk) disable iff (srst) // [R5]
        s_reg.tx_state_reg == CSX_SHIFT && sck_rise && s_reg.tx_bit_reg == CSX_LAST_BIT
        && tx_ok |=> s_reg.tx_state_reg == CSX_SHIFT && s_reg.tde_reg
        && s_reg.tx_bit_reg == 4'h0 && s_reg.tsr_reg == $past(s_reg.txbuf_reg))
        else $error("next byte not chained");
endmodule // csx_txrx

// [dv/csx_partner.sv]
`timescale 1ns/1ps
// =========================================================
// Far-side clocked serial device
// =========================================================
module csx_partner (
    input wire logic sck_pin,
    input wire logic txd,
    output logic rxd,
    output logic sck_drv
);
    logic [7:0] send_q[$];
    logic [7:0] got_q[$];
    logic [7:0] cur;
    logic [7:0] shin;
    int falls;
    int rises;

    initial begin
        rxd = 1'b1;
        sck_drv = 1'b1;
        cur = 8'h00;
        shin = 8'h00;
        falls = 0;
        rises = 0;
    end

    // Drops all framing state so a new exchange starts on a byte boundary.
    task automatic restart();
        send_q.delete();
        got_q.delete();
        falls = 0;
        rises = 0;
    endtask

    // Runs the external clock for whole bytes only, then parks it high.
    task automatic clock_bytes(input int n);
        #3;
        repeat (n * 8) begin
            #100 sck_drv = 1'b0;
            #100 sck_drv = 1'b1;
        end
    endtask

    // With nothing queued the line carries a changing pattern, not a held level.
    always @(negedge sck_pin) begin
        if (falls == 0) begin
            cur = (send_q.size() > 0) ? send_q.pop_front() : ~cur;
        end
        rxd <= cur[falls];
        falls = (falls + 1) % 8;
    end

    always @(posedge sck_pin) begin
        shin = {txd, shin[7:1]};
        rises = rises + 1;
        if (rises % 8 == 0) begin
            got_q.push_back(shin);
        end
    end
endmodule // csx_partner

// [dv/csx_txrx_test.sv]
`timescale 1ns/1ps
module csx_txrx_test;
    import csx_pkg::*;
    logic mclk;
    logic srst;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic rxd_in;
    logic sck_in;
    logic sck_out;
    logic sck_oe;
    logic txd_out;
    logic rx_fault_irq;
    logic sck_drv;
    logic sck_q;
    logic meas_clr;
    logic [7:0] rd_val;
    int mismatches;
    int checked;
    int gap;
    int max_gap;
    int sck_rises;
    logic [7:0] rst_tab [7] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h84, 8'h00, 8'h00};

    csx_txrx i_dut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_in(rxd_in),
        .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .txd_out(txd_out),
        .rx_fault_irq(rx_fault_irq));
    csx_partner i_far (.sck_pin(sck_in), .txd(txd_out), .rxd(rxd_in), .sck_drv(sck_drv));

    // The pin carries the device clock while it drives, the far side's otherwise.
    assign sck_in = sck_oe ? sck_out : sck_drv;

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // =========================================================
    // Serial clock period monitor
    // =========================================================
    always @(posedge mclk) begin
        sck_q <= sck_out;
        gap <= gap + 1;
        if (meas_clr) begin
            gap <= 0;
            max_gap <= 0;
            sck_rises <= 0;
        end else if (sck_oe && sck_out && !sck_q) begin
            sck_rises <= sck_rises + 1;
            // The lead-in before the first rise is not a clock period.
            if (sck_rises > 0 && gap + 1 > max_gap) max_gap <= gap + 1;
            gap <= 0;
        end
    end

    // =========================================================
    // Bus and checking tasks
    // =========================================================
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic reg_expect(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] v;
        reg_read(a, v);
        check(v, exp);
    endtask

    task automatic wait_flag(input int b, input logic v, input int bound);
        logic [7:0] s;
        int n;
        n = 0;
        do begin
            reg_read(CSX_STAT_ADDR, s);
            n++;
        end while (s[b] !== v && n < bound);
        if (s[b] !== v) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, s[b], v);
            end_sim();
        end
    endtask

    // =========================================================
    // Main sequence
    // =========================================================
    initial begin
        srst = 1'b1;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        meas_clr = 1'b1;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        #1;
        check({4'h0, sck_out, sck_oe, txd_out, rx_fault_irq}, 8'h0a);
        for (int i = 0; i < 7; i++) begin
            reg_read(3'(i), rd_val);
            check(rd_val, rst_tab[i]);
        end
        reg_write(CSX_RXBUF_ADDR, 8'h55);
        reg_expect(CSX_RXBUF_ADDR, 8'h00);
        reg_write(CSX_TXBUF_ADDR, 8'ha5);
        reg_expect(CSX_TXBUF_ADDR, 8'ha5);
        reg_write(CSX_RATE_ADDR, 8'h0f);
        reg_expect(CSX_RATE_ADDR, 8'h0f);
        reg_write(CSX_STAT_ADDR, 8'hff);
        reg_expect(CSX_STAT_ADDR, 8'h84);
        reg_write(CSX_STAT_ADDR, 8'h00);
        reg_expect(CSX_STAT_ADDR, 8'h04);
        $display("test registers done");

        reg_write(CSX_CTRL_ADDR, 8'h20);
        repeat (20) @(posedge mclk);
        reg_expect(CSX_STAT_ADDR, 8'h04);
        i_far.restart();
        reg_write(CSX_MODE_ADDR, 8'h80);
        meas_clr <= 1'b0;
        wait_flag(CSX_STAT_TDE_BIT, 1'b1, 20);
        check({7'h0, sck_oe}, 8'h01);
        reg_write(CSX_TXBUF_ADDR, 8'h5a);
        reg_write(CSX_STAT_ADDR, 8'h7f);
        reg_read(CSX_STAT_ADDR, rd_val);
        check({7'h0, rd_val[CSX_STAT_TDN_BIT]}, 8'h00);
        wait_flag(CSX_STAT_TDN_BIT, 1'b1, 2000);
        check(8'(i_far.got_q.size()), 8'h02);
        check(i_far.got_q[0], 8'ha5);
        check(i_far.got_q[1], 8'h5a);
        check(8'(sck_rises), 8'h10);
        check(8'(max_gap), 8'(CSX_SCK_PERIOD_CYC));
        repeat (200) @(posedge mclk);
        check({6'h0, sck_out, txd_out}, 8'h02);
        reg_write(CSX_CTRL_ADDR, 8'h00);
        $display("test transmit done");

        i_far.restart();
        i_far.send_q.push_back(8'h3c);
        i_far.send_q.push_back(8'h96);
        i_far.send_q.push_back(8'hc3);
        reg_write(CSX_CTRL_ADDR, 8'h50);
        wait_flag(CSX_STAT_RDF_BIT, 1'b1, 1000);
        reg_expect(CSX_RXBUF_ADDR, 8'h3c);
        reg_write(CSX_STAT_ADDR, 8'hbf);
        wait_flag(CSX_STAT_RDF_BIT, 1'b1, 1000);
        wait_flag(CSX_STAT_OVR_BIT, 1'b1, 1000);
        reg_expect(CSX_RXBUF_ADDR, 8'h96);
        reg_read(CSX_STAT_ADDR, rd_val);
        check(rd_val & 8'h60, 8'h60);
        check({7'h0, rx_fault_irq}, 8'h01);
        reg_write(CSX_CTRL_ADDR, 8'h10);
        repeat (3) @(posedge mclk);
        check({7'h0, rx_fault_irq}, 8'h00);
        reg_write(CSX_CTRL_ADDR, 8'h00);
        reg_write(CSX_STAT_ADDR, 8'h00);
        $display("test receive overrun done");

        i_far.restart();
        i_far.send_q.push_back(8'h81);
        reg_write(CSX_CTRL_ADDR, 8'h12);
        repeat (2) @(posedge mclk);
        check({7'h0, sck_oe}, 8'h00);
        i_far.clock_bytes(1);
        wait_flag(CSX_STAT_RDF_BIT, 1'b1, 20);
        reg_expect(CSX_RXBUF_ADDR, 8'h81);
        $display("test external clock done");
        end_sim();
    end
endmodule // csx_txrx_test
